// *** verilog/lpfec_cfg.svh ***
`ifndef LPFEC_CFG_SVH
`define LPFEC_CFG_SVH

// Register map (byte addresses on the 8-bit port)
`define LPFEC_ADDR_W          8
`define LPFEC_CONFIG_ADDR     8'h41
`define LPFEC_LINE_HI_ADDR    8'h42
`define LPFEC_LINE_LO_ADDR    8'h43
`define LPFEC_PATH_HI_ADDR    8'h44
`define LPFEC_PATH_LO_ADDR    8'h45
`define LPFEC_SYNC_HI_ADDR    8'h46
`define LPFEC_SYNC_LO_ADDR    8'h47
`define LPFEC_MODE_ADDR       8'h40

// Counter configuration field positions
`define LPFEC_CFG_EXZ_BIT     0
`define LPFEC_CFG_MOS_BIT     1
`define LPFEC_CFG_FS_BIT      2
`define LPFEC_CFG_VTYPE_BIT   3
`define LPFEC_CFG_ACCUM_BIT   4
`define LPFEC_CFG_IVAL_BIT    5
`define LPFEC_CFG_MANUAL_BIT  6
`define LPFEC_CFG_RESET       8'h00
`define LPFEC_CFG_MASK        8'h7f

// Line mode register field positions
`define LPFEC_MODE_E1_BIT     0
`define LPFEC_MODE_ZSUB_BIT   1
`define LPFEC_MODE_ESF_BIT    2
`define LPFEC_MODE_RESET      8'h00
`define LPFEC_MODE_MASK       8'h07

// Counter limits and zero-run lengths
`define LPFEC_CNT_MAX         16'hffff
`define LPFEC_ZRUN_PLAIN      5'h10
`define LPFEC_ZRUN_SUBST      5'h08

// Line rates in Hz (line clock cycles per second) and short update intervals in microseconds
`define LPFEC_LINE_T1_HZ      1544000
`define LPFEC_LINE_E1_HZ      2048000
`define LPFEC_SHORT_T1_US     42000
`define LPFEC_SHORT_E1_US     62500

`endif

// *** verilog/lpfec_pkg.sv ***
package lpfec_pkg;

  typedef struct packed {
    logic bpv;
    logic bpv_pos;
    logic subst_word;
    logic mark;
  } lpfec_line_ev_s;

  typedef struct packed {
    logic crc_err;
    logic ft_err;
    logic fs_err;
    logic fps_err;
    logic fas_err;
    logic mf_oos;
    logic sync_lost;
    logic fas_crc_lost;
    logic searching;
  } lpfec_frame_ev_s;

  typedef struct packed {
    logic [15:0] line;
    logic [15:0] path;
    logic [15:0] sync;
  } lpfec_counts_s;

endpackage : lpfec_pkg

// *** verilog/lpfec_sat_counter.sv ***
`timescale 1ns/1ps
`include "lpfec_cfg.svh"

module lpfec_sat_counter
  import lpfec_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        inc_i,
  input  wire logic        clear_i,
  output logic      [15:0] count_o
);

  // A clear takes the count now; an event in that cycle opens the next one
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      count_o <= 16'h0000;
    else if (clear_i)
      count_o <= {15'h0000, inc_i};
    else if (inc_i && count_o != `LPFEC_CNT_MAX)
      count_o <= count_o + 16'h0001;
  end

endmodule : lpfec_sat_counter

// *** verilog/lpfec_zero_run.sv ***
`timescale 1ns/1ps
`include "lpfec_cfg.svh"

module lpfec_zero_run
  import lpfec_pkg::*;
(
  input  wire logic sys_clk_i,
  input  wire logic arst_n_i,
  input  wire logic bit_i,
  input  wire logic mark_i,
  input  wire logic subst_i,
  output logic      excess_o
);

  logic [4:0] run;
  logic [4:0] limit;

  assign limit = subst_i ? `LPFEC_ZRUN_SUBST : `LPFEC_ZRUN_PLAIN;

  // One error per run; the counter parks at the limit until a mark
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      run <= 5'h00;
    else if (bit_i && mark_i)
      run <= 5'h00;
    else if (bit_i && run < limit)
      run <= run + 5'h01;
  end

  assign excess_o = bit_i && !mark_i && (run == limit - 5'h01);

endmodule : lpfec_zero_run

// *** verilog/lpfec_counters.sv ***
// Behaviour
// - T1 line counter: bipolar violations, plus excess zeros when selected.
// - T1 with zero substitution on: substituted codewords are not counted.
// - Excess zeros: 16-zero run without substitution, 8-zero run with it.
// - T1 line counter always enabled, even with receive sync lost.
// - E1 bipolar mode: two same-polarity marks make one violation.
// - E1 bipolar mode with HDB3: substitution codewords are not counted.
// - E1 type select: 0 counts bipolar, 1 counts code violations.
// - E1 line counter ignores sync loss and saturates at 65535.
// - Line count readable: high byte at 42h, low byte at 43h.
// - T1 ESF: path counter counts CRC6 errors, Fs option ignored.
// - T1 D4: path counter counts Ft errors, plus Fs when enabled.
// - T1 path counter halts while receive sync lost.
// - E1 path counter counts CRC-4 errors, halts on FAS/CRC-4 loss only.
// - Path count readable: high byte at 44h, low byte at 45h.
// - T1 multiframe mode counts out-of-sync multiframes, even in sync loss.
// - T1 alternate mode counts Ft or FPS errors, not during sync loss.
// - E1 sync counter counts FAS word errors, not while sync lost.
// - E1 FAS errors ignored while searching for alignment or multiframe.
// - Sync count readable: high byte at 46h, low byte at 47h.
// - All counters saturate at maximum, never wrap.
// - Auto update snapshots and clears once a second or on short interval.
// - Manual trigger rising edge (accumulate mode) snapshots and clears on the second clock after.
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`include "lpfec_cfg.svh"

module lpfec_counters
  import lpfec_pkg::*;
#(
  parameter int unsigned SEC_T1_CYC   = `LPFEC_LINE_T1_HZ,
  parameter int unsigned SEC_E1_CYC   = `LPFEC_LINE_E1_HZ,
  parameter int unsigned SHORT_T1_CYC =
    `LPFEC_LINE_T1_HZ / 1000 * `LPFEC_SHORT_T1_US / 1000,
  parameter int unsigned SHORT_E1_CYC =
    `LPFEC_LINE_E1_HZ / 1000 * `LPFEC_SHORT_E1_US / 1000
)
(
  input  wire logic                     sys_clk_i,
  input  wire logic                     arst_n_i,
  input  wire logic                     line_bit_i,
  input  wire lpfec_line_ev_s           line_ev_i,
  input  wire lpfec_frame_ev_s          frame_ev_i,
  input  wire logic [`LPFEC_ADDR_W-1:0] addr_i,
  input  wire logic [7:0]               wdata_i,
  input  wire logic                     wr_i,
  input  wire logic                     rd_i,
  output logic      [7:0]               rdata_o,
  output logic                          update_o
);

  // Framer events come from logic on this clock, so no synchroniser

  typedef enum logic [1:0] {
    LPFEC_IDLE = 2'b01,
    LPFEC_LOAD = 2'b10
  } lpfec_upd_e;

  logic [7:0]    counter_config_register;
  logic [7:0]    line_mode;
  logic          manual_prev;
  lpfec_upd_e    upd_state;
  lpfec_upd_e    next_upd_state;
  logic [31:0]   tick_cnt;
  logic [31:0]   tick_limit;
  logic          tick;
  logic          snap;
  lpfec_counts_s running;
  lpfec_counts_s held;
  logic          line_inc;
  logic          path_inc;
  logic          sync_inc;
  logic          prev_bpv_valid;
  logic          prev_bpv_pos;
  logic          excess_zero;
  logic [2:0]    inc_vec;
  logic          bpv_counted;
  logic          cv_match;
  logic          t1_path_ev;
  logic          e1_path_ev;
  logic          t1_fbit_ev;
  logic          e1_fas_ev;

  logic is_e1;
  logic zsub;
  logic esf;
  logic exz_sel;
  logic mos_sel;
  logic fs_sel;
  logic vtype_sel;
  logic accum_sel;
  logic ival_sel;
  logic manual_update_trigger;

  assign is_e1     = line_mode[`LPFEC_MODE_E1_BIT];
  assign zsub      = line_mode[`LPFEC_MODE_ZSUB_BIT];
  assign esf       = line_mode[`LPFEC_MODE_ESF_BIT];
  assign exz_sel   = counter_config_register[`LPFEC_CFG_EXZ_BIT];
  assign mos_sel   = counter_config_register[`LPFEC_CFG_MOS_BIT];
  assign fs_sel    = counter_config_register[`LPFEC_CFG_FS_BIT];
  assign vtype_sel = counter_config_register[`LPFEC_CFG_VTYPE_BIT];
  assign accum_sel = counter_config_register[`LPFEC_CFG_ACCUM_BIT];
  assign ival_sel  = counter_config_register[`LPFEC_CFG_IVAL_BIT];
  assign manual_update_trigger =
    counter_config_register[`LPFEC_CFG_MANUAL_BIT];

  function automatic logic hit(input logic [`LPFEC_ADDR_W-1:0] a,
                               input logic [`LPFEC_ADDR_W-1:0] b);
    hit = (a == b);
  endfunction : hit

  // Register writes
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      counter_config_register <= `LPFEC_CFG_RESET;
    else if (wr_i && hit(addr_i, `LPFEC_CONFIG_ADDR))
      counter_config_register <= wdata_i & `LPFEC_CFG_MASK;
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      line_mode <= `LPFEC_MODE_RESET;
    else if (wr_i && hit(addr_i, `LPFEC_MODE_ADDR))
      line_mode <= wdata_i & `LPFEC_MODE_MASK;
  end

  // Line code violations
  lpfec_zero_run u_zero_run (
    .sys_clk_i (sys_clk_i),
    .arst_n_i  (arst_n_i),
    .bit_i     (line_bit_i && !is_e1),
    .mark_i    (line_ev_i.mark),
    .subst_i   (zsub),
    .excess_o  (excess_zero)
  );

  // Substituted codewords are legal line code, so they do not count while substitution is on
  function automatic logic bpv_counts(input lpfec_line_ev_s ev,
                                      input logic           subst_on);
    bpv_counts = ev.bpv && !(subst_on && ev.subst_word);
  endfunction : bpv_counts

  assign bpv_counted = bpv_counts(line_ev_i, zsub);
  assign cv_match    = bpv_counted && prev_bpv_valid
                       && (prev_bpv_pos == line_ev_i.bpv_pos);

  // Remember the polarity of the previous counted bipolar violation
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      prev_bpv_valid <= 1'b0;
      prev_bpv_pos   <= 1'b0;
    end
    else if (bpv_counted)
    begin
      prev_bpv_valid <= 1'b1;
      prev_bpv_pos   <= line_ev_i.bpv_pos;
    end
  end

  // No sync gating on the line counter in either mode
  always_comb
  begin
    line_inc = 1'b0;
    if (!is_e1)
    begin
      line_inc = bpv_counted;
      if (exz_sel && excess_zero)
        line_inc = 1'b1;
    end
    else if (!vtype_sel)
      // Decoder flags a same-polarity mark pair as one bpv pulse
      line_inc = bpv_counted;
    else
      line_inc = cv_match;
  end

  // Path errors: T1 gated by sync loss, E1 only by FAS/CRC-4 loss
  assign t1_path_ev = esf ? frame_ev_i.crc_err
                          : frame_ev_i.ft_err
                            || (fs_sel && frame_ev_i.fs_err);
  assign e1_path_ev = frame_ev_i.crc_err
                      && !frame_ev_i.fas_crc_lost;

  always_comb
  begin
    path_inc = 1'b0;
    if (!is_e1)
    begin
      if (!frame_ev_i.sync_lost)
        path_inc = t1_path_ev;
    end
    else
      path_inc = e1_path_ev;
  end

  // Frame sync errors
  assign t1_fbit_ev = esf ? frame_ev_i.fps_err : frame_ev_i.ft_err;
  assign e1_fas_ev  = frame_ev_i.fas_err && !frame_ev_i.sync_lost
                      && !frame_ev_i.searching;

  always_comb
  begin
    sync_inc = 1'b0;
    if (!is_e1)
    begin
      if (mos_sel)
        sync_inc = frame_ev_i.mf_oos;
      else if (!frame_ev_i.sync_lost)
        sync_inc = t1_fbit_ev;
    end
    else
      sync_inc = e1_fas_ev;
  end

  // Update timing
  always_comb
  begin
    if (ival_sel)
      tick_limit = is_e1 ? SHORT_E1_CYC : SHORT_T1_CYC;
    else
      tick_limit = is_e1 ? SEC_E1_CYC : SEC_T1_CYC;
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      tick_cnt <= 32'h00000000;
    else if (tick || accum_sel)
      tick_cnt <= 32'h00000000;
    else
      tick_cnt <= tick_cnt + 32'h00000001;
  end

  assign tick = !accum_sel && (tick_cnt >= tick_limit - 32'h00000001);

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      manual_prev <= 1'b0;
    else
      manual_prev <= manual_update_trigger;
  end

  always_comb
  begin
    next_upd_state = LPFEC_IDLE;
    case (upd_state)
      LPFEC_IDLE:
        if ((accum_sel && manual_update_trigger && !manual_prev) || tick)
          next_upd_state = LPFEC_LOAD;
      LPFEC_LOAD:
        next_upd_state = LPFEC_IDLE;
      default:
        next_upd_state = LPFEC_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      upd_state <= LPFEC_IDLE;
    else
      upd_state <= next_upd_state;
  end

  assign snap     = (upd_state == LPFEC_LOAD);
  assign update_o = snap;
  assign inc_vec  = {line_inc, path_inc, sync_inc};

  // Counters
  generate
    for (genvar g = 0; g < 3; g++)
    begin : g_cnt
      logic [15:0] cnt;
      lpfec_sat_counter u_cnt (
        .sys_clk_i (sys_clk_i),
        .arst_n_i  (arst_n_i),
        .inc_i     (inc_vec[g]),
        .clear_i   (snap),
        .count_o   (cnt)
      );
    end
  endgenerate

  assign running.line = g_cnt[2].cnt;
  assign running.path = g_cnt[1].cnt;
  assign running.sync = g_cnt[0].cnt;

  // Both bytes read from one held snapshot, never the live count
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      held <= '0;
    else if (snap)
      held <= running;
  end

  // Read port, data valid the cycle after the strobe
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      rdata_o <= 8'h00;
    else if (rd_i)
      case (addr_i)
        `LPFEC_MODE_ADDR:    rdata_o <= line_mode;
        `LPFEC_CONFIG_ADDR:  rdata_o <= counter_config_register;
        `LPFEC_LINE_HI_ADDR: rdata_o <= held.line[15:8];
        `LPFEC_LINE_LO_ADDR: rdata_o <= held.line[7:0];
        `LPFEC_PATH_HI_ADDR: rdata_o <= held.path[15:8];
        `LPFEC_PATH_LO_ADDR: rdata_o <= held.path[7:0];
        `LPFEC_SYNC_HI_ADDR: rdata_o <= held.sync[15:8];
        `LPFEC_SYNC_LO_ADDR: rdata_o <= held.sync[7:0];
        default:             rdata_o <= 8'h00;
      endcase
    else
      rdata_o <= 8'h00;
  end

endmodule : lpfec_counters

// *** bench/lpfec_counters_monitor.sv ***
`timescale 1ns/1ps
module lpfec_chk
#(
  parameter int unsigned SEC_T1_CYC = 50,
  parameter int unsigned SEC_E1_CYC = 50
)
(
  input wire logic       sys_clk_i,
  input wire logic       arst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic       update_o
);
  localparam int GMAX = SEC_T1_CYC + SEC_E1_CYC + 4;
  logic [7:0] cfg_q;
  logic [1:0] trg;
  int         gap;
  logic       cw;
  logic       t;
  assign cw = wr_i && addr_i == 8'h41;
  assign t  = cw && wdata_i[6] && wdata_i[4] && !cfg_q[6];
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
    if (!arst_n_i)
      cfg_q <= 8'h00;
    else if (cw)
      cfg_q <= wdata_i;
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
    if (!arst_n_i)
      trg <= 2'h0;
    else
      trg <= {trg[0], t};
  // A config or mode write may restart the interval, so any write restarts the gap
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
    if (!arst_n_i)
      gap <= 0;
    else if (update_o || wr_i)
      gap <= 0;
    else
      gap <= gap + 1;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);
  chk_rd_idle:
    assert property (!rd_i |=> rdata_o == 8'h00) else $error("rd idle");
  chk_rd_unmap:
    assert property (rd_i && addr_i > 8'h47 |=> rdata_o == 8'h00)
    else $error("unmapped read");
  chk_rd_cfg:
    assert property (rd_i && addr_i == 8'h41 |=> rdata_o == {1'b0, cfg_q[6:0]})
    else $error("config read");
  chk_upd_manual:
    assert property (t |-> ##2 update_o) else $error("manual update");
  chk_upd_pulse:
    assert property (update_o |=> !update_o) else $error("update width");
  chk_upd_quiet:
    assert property (cfg_q[4] && $past(cfg_q[4], 2) && !trg[1] |-> !update_o)
    else $error("stray update");
  chk_auto_gap:
    assert property (!cfg_q[4] |-> gap <= GMAX) else $error("auto late");
  chk_auto_min:
    assert property (update_o && !cfg_q[4] |=> (!update_o || cfg_q[4]) [*8])
    else $error("auto early");
endmodule : lpfec_chk

// *** bench/lpfec_fr_model.sv ***
`timescale 1ns/1ps
module lpfec_fr_model
  import lpfec_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        arst_n_i,
  input  wire logic [31:0] rnd_i,
  input  wire logic        en_i,
  input  wire logic        flood_i,
  input  wire logic        zsub_i,
  output logic             line_bit_o,
  output lpfec_line_ev_s   line_ev_o,
  output lpfec_frame_ev_s  frame_ev_o
);
  logic q;
  logic v;
  assign q = !en_i || flood_i;
  assign v = en_i && rnd_i[31:29] == 3'h0;
  // Idle sends marks so no zero run outlives a mode change
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
    if (!arst_n_i)
    begin
      line_bit_o <= 1'b0;
      line_ev_o <= '0;
      frame_ev_o <= '0;
    end
    else
    begin
      line_bit_o <= q || v || rnd_i[1:0] != 2'h0;
      line_ev_o.mark <= q || v || rnd_i[5:2] == 4'h0;
      line_ev_o.bpv <= flood_i || v;
      line_ev_o.bpv_pos <= rnd_i[6];
      line_ev_o.subst_word <= v && zsub_i && rnd_i[7];
      frame_ev_o[8:3] <= en_i ? rnd_i[13:8] & rnd_i[19:14] : 6'h00;
      if (en_i && rnd_i[23:20] == 4'h0)
        frame_ev_o[2:0] <= frame_ev_o[2:0] ^ rnd_i[26:24];
    end
endmodule : lpfec_fr_model

// *** bench/lpfec_counters_bench.sv ***
`timescale 1ns/1ps
module lpfec_counters_bench;
  import lpfec_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic en = 1'b0;
  logic fl = 1'b0;
  logic lb;
  logic [7:0] addr = 8'h00;
  logic [7:0] wd = 8'h00;
  logic [7:0] rdata;
  logic [7:0] mode = 8'h00;
  logic [7:0] cfg = 8'h00;
  logic [31:0] rnd = 32'h02b3;
  lpfec_line_ev_s lev;
  lpfec_frame_ev_s fev;
  int error_cnt = 0;
  int n_compared = 0;
  int cnt[3] = '{0, 0, 0};
  int snap[3] = '{0, 0, 0};
  int run = 0;
  int pend = 0;
  bit pv = 1'b0;
  bit pvok = 1'b0;
  logic [7:0] tm[7] = '{8'h00, 8'h02, 8'h04, 8'h06, 8'h01, 8'h03, 8'h01};
  logic [7:0] tc[7] = '{8'h10, 8'h17, 8'h11, 8'h16, 8'h10, 8'h10, 8'h18};

  lpfec_fr_model u_fr (.sys_clk_i(clk), .arst_n_i(rst_n), .rnd_i(rnd),
    .en_i(en), .flood_i(fl), .zsub_i(mode[1]), .line_bit_o(lb),
    .line_ev_o(lev), .frame_ev_o(fev));
  lpfec_counters #(.SEC_T1_CYC(50), .SEC_E1_CYC(50), .SHORT_T1_CYC(20),
    .SHORT_E1_CYC(20)) u_dut (.sys_clk_i(clk), .arst_n_i(rst_n),
    .line_bit_i(lb), .line_ev_i(lev), .frame_ev_i(fev), .addr_i(addr),
    .wdata_i(wd), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .update_o());

  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction : xs

  initial
    forever #12.5 clk = ~clk;
  always @(posedge clk)
    rnd <= xs(rnd);

  always @(posedge clk)
  begin : model
    int inc[3];
    inc[0] = lev.bpv && !(mode[1] && lev.subst_word);
    if (mode[0] && cfg[3])
      inc[0] = inc[0] && pvok && pv == lev.bpv_pos;
    if (lev.bpv && !lev.subst_word)
    begin
      pv = lev.bpv_pos;
      pvok = 1'b1;
    end
    if (lb)
      run = lev.mark ? 0 : run + 1;
    if (!mode[0] && cfg[0] && lb && run == (mode[1] ? 8 : 16))
      inc[0] = 1;
    if (mode[0])
      inc[1] = fev.crc_err && !fev.fas_crc_lost;
    else if (fev.sync_lost)
      inc[1] = 0;
    else
      inc[1] = mode[2] ? fev.crc_err : fev.ft_err || cfg[2] && fev.fs_err;
    if (mode[0])
      inc[2] = fev.fas_err && !fev.sync_lost && !fev.searching;
    else if (cfg[1])
      inc[2] = fev.mf_oos;
    else
      inc[2] = !fev.sync_lost && (mode[2] ? fev.fps_err : fev.ft_err);
    for (int i = 0; i < 3; i++)
      if (pend == 1)
      begin
        snap[i] = cnt[i];
        cnt[i] = inc[i];
      end
      else if (cnt[i] < 65535)
        cnt[i] += inc[i];
    if (pend > 0)
      pend--;
    if (wr && addr == 8'h41 && wd[6] && wd[4] && !cfg[6])
      pend = 2;
    if (wr && addr == 8'h41)
      cfg = wd;
    if (wr && addr == 8'h40)
      mode = wd;
  end

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg

  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask : cmp

  task automatic chk_all();
    logic [7:0] h;
    logic [7:0] l;
    for (int i = 0; i < 3; i++)
    begin
      rd_reg(8'h43 + 8'(2 * i), l);
      rd_reg(8'h42 + 8'(2 * i), h);
      cmp({h, l}, 16'(snap[i]));
    end
  endtask : chk_all

  task automatic run_cfg(input logic [7:0] m, input logic [7:0] c,
                         input logic f, input int n);
    logic [7:0] v;
    wr_reg(8'h40, m);
    wr_reg(8'h41, c);
    en <= !f;
    fl <= f;
    chk_all();
    repeat (n) @(posedge clk);
    en <= 1'b0;
    fl <= 1'b0;
    repeat (3) @(posedge clk);
    wr_reg(8'h41, c | 8'h40);
    repeat (2) @(posedge clk);
    chk_all();
    rd_reg(8'h41, v);
    cmp({8'h00, v}, {8'h00, c | 8'h40});
  endtask : run_cfg

  task automatic test_done();
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done

  initial
  begin
    #2500us;
    error_cnt++;
    test_done();
  end

  initial
  begin
    logic [7:0] v;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    chk_all();
    wr_reg(8'h42, 8'hff);
    rd_reg(8'h48, v);
    cmp({8'h00, v}, 16'h0000);
    chk_all();
    wr_reg(8'h41, 8'h20);
    repeat (150) @(posedge clk);
    foreach (tm[i])
      run_cfg(tm[i], tc[i], 1'b0, 400);
    run_cfg(8'h01, 8'h10, 1'b1, 65600);
    test_done();
  end
endmodule : lpfec_counters_bench

bind lpfec_counters lpfec_chk #(.SEC_T1_CYC(SEC_T1_CYC),
  .SEC_E1_CYC(SEC_E1_CYC)) u_chk (.sys_clk_i(sys_clk_i),
  .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .update_o(update_o));
